//--- hw/spi_config_consts.svh
// Function
// - bit 7 write resets chip and registers
// - reset bit clears itself
// - reset completes within 750 ns, host idle
// - bit 5 chooses streaming address direction
// - bit 4 reads one, output line only
// - power field: 0 normal, 3 down
// - identity register returns fixed 16-bit code
// - hold bit keeps streaming address constant
// - interface setup resets to 0x30
// - power state resets to 0x00
// - streaming options reset to 0x00
`ifndef SPI_CONFIG_CONSTS_SVH
`define SPI_CONFIG_CONSTS_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_INTERFACE_SETUP 15'h0000
`define OFS_POWER_STATE 15'h0002
`define OFS_IDENTITY_LO 15'h000c
`define OFS_IDENTITY_HI 15'h000d
`define OFS_STREAMING 15'h0010
// ----------------------------------------
// fields and resets
// ----------------------------------------
`define BIT_SOFT_RESET 7
`define BIT_ASCEND 5
`define BIT_OUTPUT_LINE 4
`define BIT_ADDR_HOLD 0
`define RST_INTERFACE_SETUP 8'h30
`define RST_POWER_STATE 8'h00
`define RST_STREAMING 8'h00
`define MASK_INTERFACE_SETUP 8'h2f
`define MASK_POWER_STATE 8'hff
`define MASK_STREAMING 8'hff
`define IDENTITY_CODE 16'h5a3c
// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_MHZ 20
`define RESET_TIME_NS 750
`define RESET_CYCLES ((`RESET_TIME_NS * `CLOCK_MHZ) / 1000)
`endif

//--- hw/spi_config_pkg.sv
package spi_config_pkg;
  typedef enum logic [1:0] {
    power_normal = 2'h0,
    power_rsvd1 = 2'h1,
    power_rsvd2 = 2'h2,
    power_down = 2'h3
  } power_mode_e;
  typedef logic [14:0] reg_addr_t;
endpackage

//--- hw/spi_config_registers.sv
`timescale 1ns/100ps
`default_nettype none
`include "spi_config_consts.svh"
module spi_config_registers
  import spi_config_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register access from the serial front end
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // streaming address step
  input wire logic step_i,
  output logic [14:0] next_addr_o,
  // chip state
  output logic chip_reset_o,
  output logic busy_o,
  output logic power_down_o,
  output logic [1:0] power_mode_o,
  output logic separate_output_line_flag_o
);
  // ----------------------------------------
  // types and constants
  // ----------------------------------------
  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_clear = 2'b01,
    seq_settle = 2'b11,
    seq_release = 2'b10
  } reset_seq_e;
  localparam logic [4:0] reset_cycles = 5'(`RESET_CYCLES);
  localparam logic [4:0] count_release = 5'h02;
  localparam logic [7:0] output_line_one = 8'h01 << `BIT_OUTPUT_LINE;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] interface_setup;
  logic [7:0] power_state_control;
  logic [7:0] streaming_options;
  logic [4:0] reset_count;
  reset_seq_e reset_seq;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  logic wr_ok;
  logic rd_ok;
  logic wr_setup;
  logic wr_power;
  logic wr_stream;
  logic soft_reset;
  logic addr_hold;
  logic addr_ascend;
  power_mode_e power_field;

  function automatic logic addr_hit(
    input reg_addr_t a,
    input reg_addr_t ofs
  );
    addr_hit = a == ofs;
  endfunction

  assign wr_ok = wr_i && !busy_o;
  assign rd_ok = rd_i && !busy_o;
  assign wr_setup = wr_ok && addr_hit(addr_i, `OFS_INTERFACE_SETUP);
  assign wr_power = wr_ok && addr_hit(addr_i, `OFS_POWER_STATE);
  assign wr_stream = wr_ok && addr_hit(addr_i, `OFS_STREAMING);
  assign soft_reset = wr_setup && wdata_i[`BIT_SOFT_RESET];
  assign addr_hold = streaming_options[`BIT_ADDR_HOLD];
  assign addr_ascend = interface_setup[`BIT_ASCEND];
  assign power_field = power_mode_e'(power_state_control[1:0]);

  // ----------------------------------------
  // write data shaping
  // ----------------------------------------
  logic [7:0] setup_wdata;
  logic [7:0] power_wdata;
  logic [7:0] stream_wdata;

  function automatic logic [7:0] masked_write(
    input logic [7:0] data,
    input logic [7:0] keep
  );
    masked_write = data & keep;
  endfunction

  assign setup_wdata = masked_write(wdata_i, `MASK_INTERFACE_SETUP)
    | output_line_one;
  assign power_wdata = masked_write(wdata_i, `MASK_POWER_STATE);
  assign stream_wdata = masked_write(wdata_i, `MASK_STREAMING);

  // ----------------------------------------
  // soft reset sequencing
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reset_count <= 5'h00;
    end else if (soft_reset) begin
      reset_count <= reset_cycles;
    end else if (reset_count != 5'h00) begin
      reset_count <= reset_count - 5'h01;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reset_seq <= seq_idle;
    end else begin
      case (reset_seq)
        seq_idle: begin
          if (soft_reset) begin
            reset_seq <= seq_clear;
          end
        end
        seq_clear: begin
          reset_seq <= seq_settle;
        end
        seq_settle: begin
          if (reset_count == count_release) begin
            reset_seq <= seq_release;
          end
        end
        seq_release: begin
          reset_seq <= seq_idle;
        end
        default: begin
          reset_seq <= seq_idle;
        end
      endcase
    end
  end

  assign busy_o = reset_seq != seq_idle;
  assign chip_reset_o = busy_o;

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      interface_setup <= `RST_INTERFACE_SETUP;
    end else if (soft_reset || busy_o) begin
      interface_setup <= `RST_INTERFACE_SETUP;
    end else if (wr_setup) begin
      interface_setup <= setup_wdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      power_state_control <= `RST_POWER_STATE;
    end else if (soft_reset || busy_o) begin
      power_state_control <= `RST_POWER_STATE;
    end else if (wr_power) begin
      power_state_control <= power_wdata;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      streaming_options <= `RST_STREAMING;
    end else if (soft_reset || busy_o) begin
      streaming_options <= `RST_STREAMING;
    end else if (wr_stream) begin
      streaming_options <= stream_wdata;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  function automatic logic [7:0] read_mux(input logic [14:0] a);
    logic [15:0] ident;
    ident = `IDENTITY_CODE;
    case (a)
      `OFS_INTERFACE_SETUP: read_mux = interface_setup;
      `OFS_POWER_STATE: read_mux = power_state_control;
      `OFS_IDENTITY_LO: read_mux = ident[7:0];
      `OFS_IDENTITY_HI: read_mux = ident[15:8];
      `OFS_STREAMING: read_mux = streaming_options;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_ok) begin
      rdata_o <= read_mux(addr_i);
    end
  end

  // ----------------------------------------
  // streaming address
  // ----------------------------------------
  function automatic reg_addr_t stream_next(
    input reg_addr_t a,
    input logic hold,
    input logic ascend
  );
    if (hold) begin
      stream_next = a;
    end else if (ascend) begin
      stream_next = a + 15'h0001;
    end else begin
      stream_next = a - 15'h0001;
    end
  endfunction

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      next_addr_o <= 15'h0000;
    end else if (step_i) begin
      next_addr_o <= stream_next(addr_i, addr_hold, addr_ascend);
    end
  end

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  assign power_mode_o = power_state_control[1:0];
  assign power_down_o = power_field == power_down;
  assign separate_output_line_flag_o = interface_setup[`BIT_OUTPUT_LINE];
endmodule // spi_config_registers
`default_nettype wire

//--- verif/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // clock and state
  input wire logic clock_i, busy_i,
  // register access
  output var logic wr_o, rd_o, step_o,
  output var logic [14:0] addr_o,
  output var logic [7:0] wdata_o
);
  bit hang = 0;
  initial {wr_o,rd_o,step_o,addr_o,wdata_o} = '0;
  task automatic go(logic [2:0] k, logic [14:0] a, logic [7:0] d);
    @(negedge clock_i);
    for (int i=0; i<40 && busy_i!==1'b0; i++)
      @(negedge clock_i);
    hang |= busy_i!==1'b0;
    @(posedge clock_i);
    {wr_o,rd_o,step_o,addr_o,wdata_o} <= {k,a,d};
    @(posedge clock_i);
    {wr_o,rd_o,step_o,addr_o,wdata_o} <= {3'h0,~a,~d};
    @(negedge clock_i);
  endtask
endmodule // spi_host_model
`default_nettype wire

//--- verif/spi_config_registers_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_regs_asserts (
  input wire logic clock_i, rst_i, wr_i, rd_i, chip_reset_o, busy_o,
  input wire logic power_down_o, separate_output_line_flag_o,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  input wire logic [1:0] power_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic rd = rd_i&&!busy_o, wr = wr_i&&!busy_o;
  sequence go_s; wr&&addr_i==15'h0000&&wdata_i[7]; endsequence
  sequence run_s; busy_o ##15 !busy_o; endsequence
  a_soft_reset: assert property (go_s|=>run_s)
    else $error("soft reset");
  a_chip_busy: assert property (chip_reset_o |-> busy_o
    && power_mode_o==2'h0) else $error("chip reset");
  a_flag_one: assert property (separate_output_line_flag_o)
    else $error("flag");
  a_power_map: assert property (power_down_o==&power_mode_o)
    else $error("power down");
  a_power_write: assert property (wr&&addr_i==15'h0002
    |=> power_mode_o==$past(wdata_i[1:0])) else $error("power");
  a_reset_power: assert property ($fell(busy_o)|->power_mode_o==2'h0)
    else $error("power reset");
  a_setup_read: assert property (rd&&addr_i==15'h0000
    |=> !rdata_o[7]&&rdata_o[4]) else $error("setup");
  a_ident_read: assert property (rd&&addr_i==15'h000c
    |=> rdata_o==8'h3c) else $error("identity");
endmodule // cfg_regs_asserts
bind spi_config_registers cfg_regs_asserts chk (.*);
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_i=0, rst_i=1, wr_i, rd_i, step_i, chip_reset_o, busy_o;
  logic power_down_o, separate_output_line_flag_o;
  logic [14:0] addr_i, next_addr_o, a;
  logic [7:0] wdata_i, rdata_o;
  logic [1:0] power_mode_o;
  int n_fail=0, check_count=0;
  always #25 clock_i = ~clock_i;
  spi_config_registers dut (.*);
  spi_host_model host (.clock_i, .busy_i(busy_o), .wr_o(wr_i),
    .rd_o(rd_i), .step_o(step_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic chk(string s, logic [15:0] e, g);
    check_count++;
    if (g!==e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    if (n_fail==0 && check_count>0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [14:0] nxt(int m, logic [14:0] x);
    return m==0 ? x+15'h0001 : m==1 ? x-15'h0001 : x;
  endfunction
  initial begin
    void'($urandom(32'h23be_2dde));
    repeat (20) @(posedge clock_i);
    rst_i <= 0;
    host.go(3'h2, 15'h0000, 8'h00);
    chk("setup", 8'h30, rdata_o);
    chk("mode", 2'h0, power_mode_o);
    host.go(3'h2, 15'h0010, 8'h00);
    chk("stream", 8'h00, rdata_o);
    host.go(3'h4, 15'h000c, 8'hff);
    host.go(3'h2, 15'h000c, 8'h00);
    chk("ident", 8'h3c, rdata_o);
    host.go(3'h2, 15'h000d, 8'h00);
    chk("ident_hi", 8'h5a, rdata_o);
    for (int p=0; p<4; p++) begin
      host.go(3'h4, 15'h0002, 8'(p));
      chk("down", 16'(p==3), power_down_o);
      chk("mode", 16'(p), power_mode_o);
    end
    for (int m=0; m<3; m++) begin
      host.go(3'h4, 15'h0000, m==1 ? 8'h10 : 8'h30);
      host.go(3'h4, 15'h0010, 8'(m==2));
      for (int k=0; k<4; k++) begin
        a = k==0 ? {15{m==0}} : 15'($urandom);
        host.go(3'h1, a, 8'h00);
        chk("step", nxt(m, a), next_addr_o);
      end
    end
    host.go(3'h4, 15'h0000, 8'h00);
    host.go(3'h2, 15'h0000, 8'h00);
    chk("setup", 8'h10, rdata_o);
    chk("flag", 1'b1, separate_output_line_flag_o);
    host.go(3'h4, 15'h0000, 8'h80);
    chk("chip_reset", 1'b1, chip_reset_o);
    host.go(3'h2, 15'h0000, 8'h00);
    chk("setup", 8'h30, rdata_o);
    host.go(3'h2, 15'h0010, 8'h00);
    chk("stream", 8'h00, rdata_o);
    chk("mode", 2'h0, power_mode_o);
    a = 15'($urandom);
    host.go(3'h1, a, 8'h00);
    chk("step", nxt(0, a), next_addr_o);
    chk("hang", 0, host.hang);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
